// ### mdr_params.svh
`ifndef MDR_PARAMS_SVH
`define MDR_PARAMS_SVH
// on-chip data sram window
`define MDR_SRAM_DEPTH      1024
`define MDR_SRAM_AW         10
`define MDR_SRAM_TOP        16'h03FF
// machine cycle length in clocks
`define MDR_CLK_PER_MC      4
// access length limits in machine cycles
`define MDR_MIN_MC          4'h2
`define MDR_MAX_MC          4'h9
// opcode values
`define MDR_OP_DEC_PTR      8'hA5
// reset values
`define MDR_RST_SRAM_EN     1'b0
`define MDR_RST_PTR_SEL     1'b0
`define MDR_RST_PTR         16'h0000
`endif

// ### mdr_pkg.sv
package mdr_pkg;
   // access request from the core
   typedef struct packed {
      logic       write;
      logic [7:0] wdata;
   } mdr_req_t;
   // access controller states
   typedef enum logic [1:0] {
      MDR_IDLE  = 2'b00,
      MDR_ADDR  = 2'b01,
      MDR_DATA  = 2'b11,
      MDR_DONE  = 2'b10
   } mdr_state_t;
endpackage : mdr_pkg

// ### mdr_sram.sv
`timescale 1ns/10ps
`include "mdr_params.svh"
// on-chip data sram, flip-flop storage, synchronous read
module mdr_sram #(
   parameter int DEPTH = `MDR_SRAM_DEPTH,
   parameter int AW    = `MDR_SRAM_AW
) (
   // clock
   input  wire logic          sys_clk,
   // access
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   // storage array
   logic [7:0] mem [DEPTH];

   // write port and registered read
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : mdr_sram

// ### mdr_external_data_move_router.sv
`timescale 1ns/10ps
`include "mdr_params.svh"
// How it works
// - 1KB data sram at 0000H-03FFH
// - enabled sram serves low window accesses
// - enable is a live input, reset does not clear it
// - above 03FFH goes to external bus
// - disabled sram invisible, all external
// - access length two to nine cycles
// - machine cycle is four clocks
// - port0 bus drive, else open drain
// - port2 drives high address during bus
// - bit0 is always input only, with or without wait enable
// - second 16-bit data pointer provided
// - opcode A5H decrements active pointer
// - scratchpad separate from data sram
// - no instruction fetch from sram
// - select bit 1 picks pointer1
// - active-low read and write strobes
// - latch enable pulse before data
module mdr_external_data_move_router #(
   parameter logic [3:0] ACCESS_MC = `MDR_MIN_MC
) (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   // software control
   input  wire logic                 onchipSramEnable,
   input  wire logic [3:0]           accessMc,
   input  wire logic                 waitEnable,
   // pointer register writes
   input  wire logic                 ptrSelWe,
   input  wire logic                 ptrSelWdata,
   input  wire logic                 ptrWe,
   input  wire logic                 ptrWhich,
   input  wire logic [15:0]          ptrWdata,
   // opcode stream
   input  wire logic                 opValid,
   input  wire logic [7:0]           opCode,
   // access request
   input  wire logic                 reqValid,
   input  wire mdr_pkg::mdr_req_t    req,
   output logic                      reqReady,
   output logic                      rspValid,
   output logic [7:0]                rspData,
   // pointer state
   output logic [15:0]               dataPointer,
   output logic                      pointerSelect,
   // port 0
   input  wire logic [7:0]           port0In,
   output logic [7:0]                port0Out,
   output logic [7:0]                port0Oe_n,
   // port 2
   output logic [7:0]                port2Out,
   output logic                      port2Oe_n,
   // strobes
   output logic                      writeStrobe_n,
   output logic                      readStrobe_n,
   output logic                      addrLatchEn,
   // extra port bit 0
   input  wire logic                 extraPortBit0In,
   output logic                      extraPortBit0Oe_n
);
   // pointer pair storage
   logic [15:0]          pointer0;
   logic [15:0]          pointer1;
   // controller state
   mdr_pkg::mdr_state_t  state;
   mdr_pkg::mdr_state_t  next_state;
   // clock-in-machine-cycle divider
   logic [1:0]           phase;
   logic                 mcTick;
   // machine cycles left
   logic [3:0]           mcLeft;
   // latched access
   logic                 isWrite;
   logic                 isLocal;
   logic [15:0]          addr;
   logic [7:0]           wdata;
   // sram path
   logic                 sramWe;
   logic [7:0]           sramRdata;
   logic                 inWindow;
   logic [3:0]           lenClamp;
   logic                 waitHold;
   // request taken and where it goes
   logic                 takeReq;
   logic                 goLocal;

   // divide clock into machine cycles
   // free running, so the phase after reset is known
   // four clocks each
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end
   assign mcTick = (phase == 2'(`MDR_CLK_PER_MC - 1));

   // pointer select register
   // select bit chooses pair
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pointerSelect <= `MDR_RST_PTR_SEL;
      end else if (ptrSelWe) begin
         pointerSelect <= ptrSelWdata;
      end
   end

   // pointer pairs, load and decrement
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pointer0 <= `MDR_RST_PTR;
         pointer1 <= `MDR_RST_PTR;
      end else if (ptrWe) begin
         if (ptrWhich) begin
            pointer1 <= ptrWdata;
         end else begin
            pointer0 <= ptrWdata;
         end
      end else if (opValid && opCode == `MDR_OP_DEC_PTR) begin
         if (pointerSelect) begin
            pointer1 <= pointer1 - 16'h0001;
         end else begin
            pointer0 <= pointer0 - 16'h0001;
         end
      end
   end
   // active pointer feeds window test and bus
   assign dataPointer = pointerSelect ? pointer1 : pointer0;

   // clamp stretch to legal range
   // two to nine cycles
   always_comb begin
      if (accessMc < `MDR_MIN_MC) begin
         lenClamp = `MDR_MIN_MC;
      end else if (accessMc > `MDR_MAX_MC) begin
         lenClamp = `MDR_MAX_MC;
      end else begin
         lenClamp = accessMc;
      end
   end

   assign inWindow = (dataPointer <= `MDR_SRAM_TOP);
   assign waitHold = waitEnable && !extraPortBit0In;
   // pin is always input only, whether or not wait is enabled
   assign extraPortBit0Oe_n = 1'b1;

   // accept only when idle on a cycle boundary
   assign reqReady = (state == mdr_pkg::MDR_IDLE) && mcTick;
   // starting on a boundary keeps every access whole machine cycles
   // request taken at this edge
   assign takeReq  = reqValid && reqReady;
   // enabled low window stays on chip
   assign goLocal  = onchipSramEnable && inWindow;

   // next-state logic
   always_comb begin
      next_state = state;
      case (state)
         mdr_pkg::MDR_IDLE: begin
            if (reqValid && reqReady) begin
               next_state = mdr_pkg::MDR_ADDR;
            end
         end
         mdr_pkg::MDR_ADDR: begin
            if (mcTick) begin
               next_state = mdr_pkg::MDR_DATA;
            end
         end
         mdr_pkg::MDR_DATA: begin
            if (mcTick && mcLeft == 4'h1 && !(waitHold && !isLocal)) begin
               next_state = mdr_pkg::MDR_DONE;
            end
         end
         mdr_pkg::MDR_DONE: begin
            next_state = mdr_pkg::MDR_IDLE;
         end
         default: begin
            next_state = mdr_pkg::MDR_IDLE;
         end
      endcase
   end

   // state register
   // gray path moves one bit per step
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= mdr_pkg::MDR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // latch access and count machine cycles
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         isWrite <= 1'b0;
         isLocal <= 1'b0;
         addr    <= 16'h0000;
         wdata   <= 8'h00;
         mcLeft  <= 4'h0;
      end else if (state == mdr_pkg::MDR_IDLE && reqValid && reqReady) begin
         isWrite <= req.write;
         wdata   <= req.wdata;
         addr    <= dataPointer;
         isLocal <= onchipSramEnable && inWindow;
         // address cycle counts as the first
         mcLeft  <= lenClamp - 4'h1;
      end else if (state == mdr_pkg::MDR_DATA && mcTick && mcLeft != 4'h1) begin
         mcLeft <= mcLeft - 4'h1;
      end
   end

   assign sramWe = (state == mdr_pkg::MDR_ADDR) && mcTick && isLocal && isWrite;

   mdr_sram #(
      .DEPTH (`MDR_SRAM_DEPTH),
      .AW    (`MDR_SRAM_AW)
   ) u_sram (
      .sys_clk (sys_clk),
      .we      (sramWe),
      .addr    (addr[`MDR_SRAM_AW-1:0]),
      .wdata   (wdata),
      .rdata   (sramRdata)
   );

   // response data capture
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rspValid <= 1'b0;
         rspData  <= 8'h00;
      end else begin
         rspValid <= (state == mdr_pkg::MDR_DONE);
         // taken while the read strobe is still low
         if (state == mdr_pkg::MDR_DATA && next_state == mdr_pkg::MDR_DONE && !isWrite) begin
            rspData <= isLocal ? sramRdata : port0In;
         end
      end
   end

   // external bus pins, registered
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         port0Out      <= 8'hFF;
         port0Oe_n     <= 8'hFF;
         port2Out      <= 8'hFF;
         port2Oe_n     <= 1'b1;
         addrLatchEn   <= 1'b0;
         writeStrobe_n <= 1'b1;
         readStrobe_n  <= 1'b1;
      end else if (takeReq) begin
         // route chosen from live inputs, never from the last access
         // one-clock latch pulse with address
         addrLatchEn <= !goLocal;
         // local access leaves the bus idle
         if (!goLocal) begin
            port0Out  <= dataPointer[7:0];
            port0Oe_n <= 8'h00;
            port2Out  <= dataPointer[15:8];
            port2Oe_n <= 1'b0;
         end
      end else if (state == mdr_pkg::MDR_ADDR && !isLocal) begin
         // latch pulse ends after one clock
         addrLatchEn <= 1'b0;
         if (mcTick) begin
            writeStrobe_n <= !isWrite;
            readStrobe_n  <= isWrite;
            port0Out      <= wdata;
            port0Oe_n     <= isWrite ? 8'h00 : 8'hFF;
         end
      end else if (next_state == mdr_pkg::MDR_DONE || state == mdr_pkg::MDR_DONE) begin
         // release to open-drain idle
         // strobes rise before the next request can start
         writeStrobe_n <= 1'b1;
         readStrobe_n  <= 1'b1;
         addrLatchEn   <= 1'b0;
         port0Oe_n     <= 8'hFF;
         port2Oe_n     <= 1'b1;
      end else begin
         addrLatchEn <= 1'b0;
      end
   end
endmodule : mdr_external_data_move_router

// ### mdr_external_data_move_router_props.sv
`timescale 1ns/10ps
// concurrent checks on the router ports
module mdr_external_data_move_router_props (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // control and requests
   input wire logic        onchipSramEnable,
   input wire logic [3:0]  accessMc,
   input wire logic        waitEnable,
   input wire logic        ptrSelWe,
   input wire logic        ptrSelWdata,
   input wire logic        ptrWe,
   input wire logic        opValid,
   input wire logic [7:0]  opCode,
   input wire logic        reqValid,
   input wire logic        reqReady,
   // observed outputs
   input wire logic [15:0] dataPointer,
   input wire logic        pointerSelect,
   input wire logic [7:0]  port0Oe_n,
   input wire logic [7:0]  port2Out,
   input wire logic        port2Oe_n,
   input wire logic        writeStrobe_n,
   input wire logic        readStrobe_n,
   input wire logic        addrLatchEn,
   input wire logic        extraPortBit0Oe_n
);
   wire       take    = reqValid && reqReady;                          // accepted request
   wire       isLocal = onchipSramEnable && (dataPointer <= 16'h03FF); // served on chip
   wire [7:0] ptrHigh = dataPointer[15:8];                             // high address byte
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_highAddr;
      take && !isLocal |=> !port2Oe_n && port2Out == $past(ptrHigh);
   endproperty
   a_highAddr: assert property (p_highAddr) else $error("high address wrong");
   property p_localQuiet;
      take && isLocal |=> (readStrobe_n && writeStrobe_n && !addrLatchEn)[*4];
   endproperty
   a_localQuiet: assert property (p_localQuiet) else $error("bus moved on local");
   property p_decrement;
      opValid && opCode == 8'hA5 && !ptrWe && !ptrSelWe |=>
         dataPointer == $past(dataPointer) - 16'h0001;
   endproperty
   a_decrement: assert property (p_decrement) else $error("pointer not lowered");
   property p_select;
      ptrSelWe |=> pointerSelect == $past(ptrSelWdata);
   endproperty
   a_select: assert property (p_select) else $error("select not taken");
   property p_readBus;
      !readStrobe_n |-> port0Oe_n == 8'hFF && writeStrobe_n;
   endproperty
   a_readBus: assert property (p_readBus) else $error("port0 driven in read");
   property p_latch;
      take && !isLocal |=> addrLatchEn ##4 (!addrLatchEn && !(readStrobe_n && writeStrobe_n));
   endproperty
   a_latch: assert property (p_latch) else $error("latch pulse wrong");
   property p_length;
      $fell(readStrobe_n) && accessMc == 4'h2 && !waitEnable |-> !readStrobe_n[*4] ##1 readStrobe_n;
   endproperty
   a_length: assert property (p_length) else $error("strobe length wrong");
   property p_waitIn;
      waitEnable |-> extraPortBit0Oe_n;
   endproperty
   a_waitIn: assert property (p_waitIn) else $error("wait pin driven");
   // main scenarios
   c_local: cover property (take && isLocal);
   c_ext: cover property (take && !isLocal);
   c_dec: cover property (opValid && opCode == 8'hA5);
endmodule : mdr_external_data_move_router_props

bind mdr_external_data_move_router mdr_external_data_move_router_props u_props (.sys_clk, .rst, .onchipSramEnable,
   .accessMc, .waitEnable, .ptrSelWe, .ptrSelWdata, .ptrWe, .opValid, .opCode, .reqValid,
   .reqReady, .dataPointer, .pointerSelect, .port0Oe_n, .port2Out, .port2Oe_n,
   .writeStrobe_n, .readStrobe_n, .addrLatchEn, .extraPortBit0Oe_n);

// ### mdr_ext_mem.sv
`timescale 1ns/10ps
// far-side memory on the multiplexed bus
module mdr_ext_mem (
   // clock
   input  wire logic       sys_clk,
   // bus from the router
   input  wire logic       addrLatchEn,
   input  wire logic [7:0] port0Out,
   input  wire logic [7:0] port0Oe_n,
   input  wire logic [7:0] port2Out,
   input  wire logic       readStrobe_n,
   input  wire logic       writeStrobe_n,
   // slow answer on command
   input  wire logic       slow,
   // resolved pins
   output logic      [7:0] port0In,
   output logic            extraPortBit0In
);
   logic [7:0]  mem [0:65535];             // storage, preset pattern
   logic [7:0]  lowAddr = 8'h00;           // latched low address
   logic [7:0]  lastBus = 8'h00;           // last wire level
   logic [3:0]  holdCnt = 4'h0;            // clocks into strobe
   wire  [15:0] addr = {port2Out, lowAddr}; // full address
   initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'hC3;
   always @(posedge sys_clk) begin
      lastBus <= port0In;
      if (addrLatchEn) lowAddr <= port0In;
      if (!writeStrobe_n) mem[addr] <= port0In;
      holdCnt <= (readStrobe_n && writeStrobe_n) ? 4'h0 : holdCnt + 4'(holdCnt != 4'hF);
   end
   // released lines show memory data while read strobe is low, else inverse of last level
   always_comb for (int b = 0; b < 8; b++)
      port0In[b] = !port0Oe_n[b] ? port0Out[b] : !readStrobe_n ? mem[addr][b] : ~lastBus[b];
   // pulled-up wait line, low early in a slow strobe
   assign extraPortBit0In = !(slow && !(readStrobe_n && writeStrobe_n) && holdCnt < 4'h8);
endmodule : mdr_ext_mem

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
   logic              sys_clk = 0, rst = 1, onchipSramEnable = 0, waitEnable = 0, slow = 0;
   logic              ptrSelWe = 0, ptrSelWdata = 0, ptrWe = 0, ptrWhich = 0, opValid = 0;
   logic              reqValid = 0, reqReady, rspValid, pointerSelect, port2Oe_n, sawAle;
   logic              writeStrobe_n, readStrobe_n, addrLatchEn, extraPortBit0Oe_n;
   logic              extraPortBit0In;
   logic [3:0]        accessMc = 4'h2;
   logic [7:0]        opCode = 8'h00;
   logic [7:0]        rspData, port0Out, port0Oe_n, port2Out, port0In;
   logic [15:0]       ptrWdata = 16'h0000, dataPointer;
   mdr_pkg::mdr_req_t req = '0;
   int                failures = 0, compares = 0, lastLat;
   mdr_external_data_move_router u_dut (.sys_clk, .rst, .onchipSramEnable, .accessMc, .waitEnable, .ptrSelWe,
      .ptrSelWdata, .ptrWe, .ptrWhich, .ptrWdata, .opValid, .opCode, .reqValid, .req, .reqReady,
      .rspValid, .rspData, .dataPointer, .pointerSelect, .port0In, .port0Out, .port0Oe_n,
      .port2Out, .port2Oe_n, .writeStrobe_n, .readStrobe_n, .addrLatchEn, .extraPortBit0In,
      .extraPortBit0Oe_n);
   mdr_ext_mem u_mem (.sys_clk, .addrLatchEn, .port0Out, .port0Oe_n, .port2Out, .readStrobe_n,
      .writeStrobe_n, .slow, .port0In, .extraPortBit0In);
   // 50 ns clock
   initial forever #25 sys_clk = ~sys_clk;
   task report_and_stop;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task chk(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         failures++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk
   // one-cycle pointer load, select write, opcode
   task pulse(input int kind, input logic [15:0] v);
      @(negedge sys_clk);
      {ptrWe, ptrSelWe, opValid} = 3'b100 >> kind;
      {ptrWhich, ptrSelWdata, ptrWdata, opCode} = {v[0], v[0], v, v[7:0]};
      @(negedge sys_clk);
      {ptrWe, ptrSelWe, opValid} = 3'b000;
   endtask : pulse
   // one access, latency and bus use recorded
   task acc(input logic wr, input logic [7:0] wd, input logic ext, input logic [7:0] exp);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (reqReady !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      reqValid = 1;
      req = {wr, wd};
      @(negedge sys_clk);
      reqValid = 0;
      sawAle = 0;
      lastLat = 0;
      while (rspValid !== 1'b1 && lastLat < 80) begin
         sawAle |= addrLatchEn;
         @(negedge sys_clk);
         lastLat++;
      end
      if (n >= 40 || lastLat >= 80) begin
         failures++;
         report_and_stop;
      end
      chk(sawAle === ext, "bus use wrong");
      if (!wr) chk(rspData === exp, "read data wrong");
   endtask : acc
   task s_default;
      pulse(0, 16'h0000);
      pulse(0, 16'h0010);
      acc(1, 8'h96, 1, 8'h00);
      chk(lastLat === 9, "short length");
      chk(u_mem.mem[16'h0010] === 8'h96, "far write lost");
      acc(0, 8'h00, 1, 8'h96);
   endtask : s_default
   task s_local;
      onchipSramEnable = 1;
      pulse(0, 16'h0001);
      pulse(1, 16'h0001);
      chk(dataPointer === 16'h0001 && pointerSelect === 1'b1, "select");
      pulse(0, 16'h03FF);
      acc(1, 8'h5A, 0, 8'h00);
      chk(u_mem.mem[16'h03FF] === 8'h3C, "far copy touched");
      acc(0, 8'h00, 0, 8'h5A);
      onchipSramEnable = 0;
      acc(0, 8'h00, 1, 8'h3C);
      onchipSramEnable = 1;
      pulse(1, 16'h0000);
      pulse(0, 16'h0400);
      acc(0, 8'h00, 1, 8'hC3);
      pulse(2, 16'h0000);
      chk(dataPointer === 16'h0400, "other opcode moved");
      pulse(2, 16'h00A5);
      chk(dataPointer === 16'h03FF, "no decrement");
      acc(0, 8'h00, 0, 8'h5A);
      pulse(0, 16'h0400);
   endtask : s_local
   task s_length;
      logic [3:0] mcs [4] = '{4'h1, 4'h2, 4'h9, 4'hF};
      int         lat [4] = '{9, 9, 37, 37};
      for (int i = 0; i < 4; i++) begin
         accessMc = mcs[i];
         acc(1, 8'(i), 1, 8'h00);
         chk(lastLat === lat[i], "stretch length");
      end
      accessMc = 4'h2;
   endtask : s_length
   task s_wait;
      waitEnable = 1;
      slow = 1;
      acc(1, 8'hE1, 1, 8'h00);
      chk(lastLat > 10, "wait ignored");
      acc(0, 8'h00, 1, 8'hE1);
      waitEnable = 0;
      slow = 0;
   endtask : s_wait
   initial begin
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 0;
      s_default();
      s_local();
      s_length();
      s_wait();
      report_and_stop();
   end
endmodule : testbench
